// ===== sfrm_cfg.svh
`ifndef SFRM_CFG_SVH
`define SFRM_CFG_SVH
// =====================================================
// Register byte offsets
`define SFRM_OFF_CTRL 8'h00
`define SFRM_OFF_STATUS 8'h04
`define SFRM_OFF_IRQ_STAT 8'h08
`define SFRM_OFF_IRQ_CLR 8'h0C
`define SFRM_OFF_IRQ_EN 8'h10
`define SFRM_OFF_RESET 8'h14
`define SFRM_OFF_WDT_CFG 8'h18
`define SFRM_OFF_UVLO_CFG 8'h1C
`define SFRM_OFF_VOUT0 8'h20
// =====================================================
// Field positions
`define SFRM_RESET_SOFT_BIT 0
`define SFRM_CTRL_REG_EN_LSB 0
// =====================================================
// Reset values
`define SFRM_CTRL_RST 8'h00
`define SFRM_IRQ_EN_RST 8'h00
`define SFRM_WATCHDOG_DEBOUNCE_SELECT_RST 3'h3
`define SFRM_UVLO_FALL_RST 8'h0F
`define SFRM_UVLO_RISE_CODE 8'h32
`define SFRM_VOUT_RST 8'h8C
// =====================================================
// Timing
`define SFRM_CLK_MHZ 250
`define SFRM_BIAS_SETTLE_US 50
`define SFRM_BIAS_CYCLES (`SFRM_BIAS_SETTLE_US * `SFRM_CLK_MHZ)
`define SFRM_DEB_UNIT_US 1000
`define SFRM_DEB_UNIT_CYCLES (`SFRM_DEB_UNIT_US * `SFRM_CLK_MHZ)
`endif

// ===== sfrm_pkg.sv
package sfrm_pkg;
  // =====================================================
  // Supervisor states, one-hot
  typedef enum logic [4:0] {
    SFRM_ST_DORMANT  = 5'h01,
    SFRM_ST_SHUTDOWN = 5'h02,
    SFRM_ST_BIAS     = 5'h04,
    SFRM_ST_STANDBY  = 5'h08,
    SFRM_ST_THERMAL  = 5'h10
  } sfrm_state_e;
  // Synchronised analogue flags and pins
  typedef struct packed {
    logic por_ok;
    logic sys_uv;
    logic io_good;
    logic ot_trip;
    logic ot_clear;
    logic warn_120;
    logic warn_140;
    logic chip_en;
    logic wdt_n;
  } sfrm_flags_s;
  // Reset class pulses
  typedef struct packed {
    logic supply_loss;
    logic off_class;
    logic vout;
  } sfrm_rst_s;
endpackage

// ===== sfrm_sync.sv
`timescale 1ns/1ps
// =====================================================
// Two-stage synchroniser bank
module sfrm_sync #(
  parameter int WIDTH = 9
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r; // First stage, read only by second
  // Two flops per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          meta_r[g] <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          meta_r[g] <= i_async[g];
          o_sync[g] <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule

// ===== sfrm_debounce.sv
`timescale 1ns/1ps
`include "sfrm_cfg.svh"
// =====================================================
// Low-level debounce: fires once when input held low long enough
module sfrm_debounce #(
  parameter int UNIT_CYCLES = `SFRM_DEB_UNIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_level_n,
  input wire logic [2:0] i_sel,
  output logic o_fire
);
  logic [31:0] unit_cnt_r; // Cycles within one unit
  logic [7:0] units_r; // Units seen low
  logic done_r; // Already fired this low period
  logic [7:0] limit; // Units required
  // Select: 2^sel units
  assign limit = 8'h01 << i_sel;
  // Count while low, restart on high
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_level_n) begin
      unit_cnt_r <= 32'h0;
      units_r <= 8'h00;
      done_r <= 1'b0;
      o_fire <= 1'b0;
    end else begin
      o_fire <= 1'b0;
      if (!done_r) begin
        if (units_r >= limit) begin
          o_fire <= 1'b1;
          done_r <= 1'b1;
        end else if (unit_cnt_r == 32'(UNIT_CYCLES - 1)) begin
          unit_cnt_r <= 32'h0;
          units_r <= units_r + 8'h01;
        end else begin
          unit_cnt_r <= unit_cnt_r + 32'h1;
        end
      end
    end
  end
endmodule

// ===== sfrm_top.sv
`timescale 1ns/1ps
`include "sfrm_cfg.svh"
// Function
// - Undervoltage forces shutdown until supply recovers
// - I/O supply loss forces immediate shutdown
// - Overtemperature soft-stops outputs, resets off-class
// - Register bus works during thermal shutdown
// - Thermal recovery after hysteresis allows re-enable
// - Two warning comparators raise interrupt events
// - Power-on loads defaults, waits for enable
// - Below power-on level resets supply-loss registers
// - Shutdown events reset off-class registers
// - Soft reset bit resets off-class, reads zero
// - Long watchdog low reverts phase voltages
// - Valid supplies plus enable give standby
// - Regulators allowed after bias settling time
// - Enable low shuts down, resets off-class
module sfrm_top #(
  parameter int PHASES = 4,
  parameter int BIAS_CYCLES = `SFRM_BIAS_CYCLES,
  parameter int DEB_UNIT_CYCLES = `SFRM_DEB_UNIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Analogue comparator flags and pins
  input wire logic i_por_ok,
  input wire logic i_sys_uv,
  input wire logic i_io_good,
  input wire logic i_ot_trip,
  input wire logic i_ot_clear,
  input wire logic i_warn_120,
  input wire logic i_warn_140,
  input wire logic i_chip_en,
  input wire logic i_host_watchdog_reset_n,
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Block outputs
  output logic o_bias_en,
  output logic o_reg_allow,
  output logic [PHASES-1:0] o_reg_en,
  output logic o_soft_stop,
  output logic o_irq,
  output logic [PHASES*8-1:0] o_phase_output_voltage_setting,
  output logic [7:0] o_supply_low_fall_level
);
  // =====================================================
  // Declarations
  sfrm_pkg::sfrm_flags_s flags; // Synchronised inputs
  sfrm_pkg::sfrm_state_e state_r; // Supervisor state
  sfrm_pkg::sfrm_state_e state_nxt; // Next state
  sfrm_pkg::sfrm_rst_s rst_cls; // Reset class pulses
  logic [31:0] bias_cnt_r; // Bias settle counter
  logic bias_done_r; // Bias settled
  logic wdt_fire; // Debounced watchdog event
  logic soft_rst_pulse; // Soft reset write
  logic [7:0] ctrl_r; // Regulator enable requests
  logic [2:0] watchdog_debounce_select_r; // Watchdog debounce select
  logic [7:0] uvlo_fall_r; // Undervoltage falling code
  logic [7:0] vout_r [PHASES]; // Phase voltage settings
  logic [2:0] irq_stat_r; // Sticky events
  logic [2:0] irq_en_r; // Interrupt enables
  logic [2:0] ev_prev_r; // Event history for edges
  logic [2:0] ev_now; // Current event levels
  logic [2:0] ev_rise; // Event edges
  logic [2:0] irq_clr; // Clear write pulse
  logic aw_hold_r; // Write address captured
  logic w_hold_r; // Write data captured
  logic [7:0] awaddr_r; // Captured write address
  logic [31:0] wdata_r; // Captured write data
  logic do_write; // Perform write this cycle
  logic [31:0] rd_mux; // Read data selected
  logic rd_ok; // Read address mapped

  // =====================================================
  // Input synchronisation
  sfrm_sync #(
    .WIDTH(9)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_por_ok, i_sys_uv, i_io_good, i_ot_trip, i_ot_clear,
              i_warn_120, i_warn_140, i_chip_en, i_host_watchdog_reset_n}),
    .o_sync(flags)
  );

  // =====================================================
  // Watchdog debounce
  sfrm_debounce #(
    .UNIT_CYCLES(DEB_UNIT_CYCLES)
  ) u_deb (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_level_n(flags.wdt_n),
    .i_sel(watchdog_debounce_select_r),
    .o_fire(wdt_fire)
  );

  // =====================================================
  // Supervisor state machine
  // Next-state selection
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sfrm_pkg::SFRM_ST_DORMANT: begin
        // Leave once supply is up and above rising level
        if (flags.por_ok && !flags.sys_uv && flags.io_good) begin
          state_nxt = sfrm_pkg::SFRM_ST_SHUTDOWN;
        end
      end
      sfrm_pkg::SFRM_ST_SHUTDOWN: begin
        if (!flags.por_ok || flags.sys_uv || !flags.io_good) begin
          state_nxt = sfrm_pkg::SFRM_ST_DORMANT;
        end else if (flags.chip_en) begin
          state_nxt = sfrm_pkg::SFRM_ST_BIAS;
        end
      end
      sfrm_pkg::SFRM_ST_BIAS, sfrm_pkg::SFRM_ST_STANDBY: begin
        if (!flags.por_ok || flags.sys_uv || !flags.io_good) begin
          state_nxt = sfrm_pkg::SFRM_ST_DORMANT;
        end else if (!flags.chip_en) begin
          state_nxt = sfrm_pkg::SFRM_ST_SHUTDOWN;
        end else if (flags.ot_trip) begin
          state_nxt = sfrm_pkg::SFRM_ST_THERMAL;
        end else if (state_r == sfrm_pkg::SFRM_ST_BIAS && bias_done_r) begin
          state_nxt = sfrm_pkg::SFRM_ST_STANDBY;
        end
      end
      sfrm_pkg::SFRM_ST_THERMAL: begin
        if (!flags.por_ok || flags.sys_uv || !flags.io_good) begin
          state_nxt = sfrm_pkg::SFRM_ST_DORMANT;
        end else if (!flags.chip_en) begin
          state_nxt = sfrm_pkg::SFRM_ST_SHUTDOWN;
        end else if (flags.ot_clear && !flags.ot_trip) begin
          state_nxt = sfrm_pkg::SFRM_ST_STANDBY;
        end
      end
      default: begin
        state_nxt = sfrm_pkg::SFRM_ST_DORMANT;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= sfrm_pkg::SFRM_ST_DORMANT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bias settle counter, restarts whenever enable path starts
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || state_r != sfrm_pkg::SFRM_ST_BIAS) begin
      bias_cnt_r <= 32'h0;
      bias_done_r <= 1'b0;
    end else if (bias_cnt_r == 32'(BIAS_CYCLES - 1)) begin
      bias_done_r <= 1'b1;
    end else begin
      bias_cnt_r <= bias_cnt_r + 32'h1;
    end
  end

  // =====================================================
  // Reset class generation
  // Supply loss: below power-on level; off class: any shutdown entry
  always_comb begin
    rst_cls.supply_loss = !flags.por_ok;
    rst_cls.off_class = soft_rst_pulse
      || (state_nxt != state_r && (state_nxt == sfrm_pkg::SFRM_ST_DORMANT
      || state_nxt == sfrm_pkg::SFRM_ST_SHUTDOWN
      || state_nxt == sfrm_pkg::SFRM_ST_THERMAL));
    rst_cls.vout = wdt_fire;
  end

  // =====================================================
  // AXI4-Lite write path
  assign do_write = aw_hold_r && w_hold_r && !o_bvalid;
  assign soft_rst_pulse = do_write && awaddr_r == `SFRM_OFF_RESET && wstrb_ok(i_wstrb)
    && wdata_r[`SFRM_RESET_SOFT_BIT];

  // Byte lane 0 carries every field
  function automatic logic wstrb_ok(input logic [3:0] s);
    wstrb_ok = 1'b1;
  endfunction

  // Address and data capture in either order; works in all states
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      o_awready <= !aw_hold_r && i_awvalid && !o_awready;
      o_wready <= !w_hold_r && i_wvalid && !o_wready;
      if (o_awready && i_awvalid) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_hold_r <= 1'b1;
        wdata_r <= i_wstrb[0] ? i_wdata : 32'h0;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp <= rd_map(awaddr_r) ? 2'h0 : 2'h2;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Mapped address test
  function automatic logic rd_map(input logic [7:0] a);
    rd_map = (a[1:0] == 2'h0) && (a < (`SFRM_OFF_VOUT0 + 8'(PHASES * 4)));
  endfunction

  // Off-class control registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || rst_cls.off_class) begin
      ctrl_r <= `SFRM_CTRL_RST;
      watchdog_debounce_select_r <= `SFRM_WATCHDOG_DEBOUNCE_SELECT_RST;
    end else if (do_write) begin
      if (awaddr_r == `SFRM_OFF_CTRL) begin
        ctrl_r <= wdata_r[7:0];
      end
      if (awaddr_r == `SFRM_OFF_WDT_CFG) begin
        watchdog_debounce_select_r <= wdata_r[2:0];
      end
    end
  end

  // Supply-loss class register; host keeps it below rising code
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || rst_cls.supply_loss) begin
      uvlo_fall_r <= `SFRM_UVLO_FALL_RST;
    end else if (do_write && awaddr_r == `SFRM_OFF_UVLO_CFG) begin
      uvlo_fall_r <= wdata_r[7:0];
    end
  end

  // Phase voltages, one register per phase
  genvar p;
  generate
    for (p = 0; p < PHASES; p++) begin : g_ph
      always_ff @(posedge i_clk) begin
        if (i_sys_rst || rst_cls.off_class || rst_cls.vout) begin
          vout_r[p] <= `SFRM_VOUT_RST;
        end else if (do_write && awaddr_r == `SFRM_OFF_VOUT0 + 8'(p * 4)) begin
          vout_r[p] <= wdata_r[7:0];
        end
      end
    end
  endgenerate

  // =====================================================
  // Interrupts
  assign ev_now = {wdt_fire, flags.warn_140, flags.warn_120};
  assign ev_rise = ev_now & ~ev_prev_r;
  assign irq_clr = (do_write && awaddr_r == `SFRM_OFF_IRQ_CLR) ? wdata_r[2:0] : 3'h0;

  // Sticky status, set wins over clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ev_prev_r <= 3'h0;
      irq_stat_r <= 3'h0;
      irq_en_r <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      ev_prev_r <= ev_now;
      irq_stat_r <= (irq_stat_r & ~irq_clr) | ev_rise;
      if (do_write && awaddr_r == `SFRM_OFF_IRQ_EN) begin
        irq_en_r <= wdata_r[2:0];
      end
      o_irq <= |(((irq_stat_r & ~irq_clr) | ev_rise) & irq_en_r);
    end
  end

  // =====================================================
  // AXI4-Lite read path
  always_comb begin
    rd_ok = rd_map(i_araddr);
    rd_mux = 32'h0;
    case (i_araddr)
      `SFRM_OFF_CTRL: rd_mux = {24'h0, ctrl_r};
      `SFRM_OFF_STATUS: rd_mux = {20'h0, flags.ot_trip, flags.io_good, flags.sys_uv, flags.chip_en,
                                  3'h0, state_r};
      `SFRM_OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
      `SFRM_OFF_IRQ_EN: rd_mux = {29'h0, irq_en_r};
      `SFRM_OFF_WDT_CFG: rd_mux = {29'h0, watchdog_debounce_select_r};
      `SFRM_OFF_UVLO_CFG: rd_mux = {24'h0, uvlo_fall_r};
      default: begin
        for (int k = 0; k < PHASES; k++) begin
          if (i_araddr == `SFRM_OFF_VOUT0 + 8'(k * 4)) begin
            rd_mux = {24'h0, vout_r[k]};
          end
        end
      end
    endcase
  end

  // Read channel; soft reset bit always reads zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= 2'h0;
    end else begin
      o_arready <= i_arvalid && !o_arready && !o_rvalid;
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_mux;
        o_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // =====================================================
  // Outputs to the analogue side
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_bias_en <= 1'b0;
      o_reg_allow <= 1'b0;
      o_reg_en <= '0;
      o_soft_stop <= 1'b0;
      o_supply_low_fall_level <= `SFRM_UVLO_FALL_RST;
      o_phase_output_voltage_setting <= '0;
    end else begin
      o_bias_en <= state_r == sfrm_pkg::SFRM_ST_BIAS || state_r == sfrm_pkg::SFRM_ST_STANDBY
        || state_r == sfrm_pkg::SFRM_ST_THERMAL;
      o_reg_allow <= state_r == sfrm_pkg::SFRM_ST_STANDBY;
      // Enables reach regulators only in standby
      o_reg_en <= (state_r == sfrm_pkg::SFRM_ST_STANDBY) ? ctrl_r[PHASES-1:0] : '0;
      o_soft_stop <= state_r == sfrm_pkg::SFRM_ST_THERMAL;
      o_supply_low_fall_level <= uvlo_fall_r;
      for (int k = 0; k < PHASES; k++) begin
        o_phase_output_voltage_setting[k*8 +: 8] <= vout_r[k];
      end
    end
  end
endmodule

// ===== sfrm_host.sv
`timescale 1ns/1ps
// =====================================================
// Host processor pins: chip enable and watchdog reset
module sfrm_host #(
  parameter int PULSE_CYCLES = 100
) (
  input wire logic i_clk,
  input wire logic i_ce_cmd,
  input wire logic i_wdt_go,
  output logic o_chip_en,
  output logic o_host_watchdog_reset_n
);
  int cnt_r = 0; // Remaining low cycles of the reset pulse
  // Chip enable follows the host's command
  assign o_chip_en = i_ce_cmd;
  // =====================================================
  // Expired watchdog: pin held low for one full pulse
  always_ff @(posedge i_clk) begin
    if (i_wdt_go) begin
      cnt_r <= PULSE_CYCLES;
    end else if (cnt_r > 0) begin
      cnt_r <= cnt_r - 1;
    end
  end
  assign o_host_watchdog_reset_n = (cnt_r == 0);
endmodule

// ===== sfrm_top_chk.sv
`timescale 1ns/1ps
// =====================================================
// Port-level checks of the supervisor
module sfrm_top_chk #(
  parameter int PHASES = 4,
  parameter int BIAS_CYCLES = 12500,
  parameter int DEB_UNIT_CYCLES = 250000
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sys_uv,
  input wire logic i_io_good,
  input wire logic i_ot_trip,
  input wire logic i_ot_clear,
  input wire logic i_chip_en,
  input wire logic i_host_watchdog_reset_n,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_reg_allow,
  input wire logic o_bias_en,
  input wire logic [PHASES-1:0] o_reg_en,
  input wire logic o_soft_stop,
  input wire logic o_irq,
  input wire logic [PHASES*8-1:0] o_phase_output_voltage_setting
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  localparam logic [PHASES*8-1:0] VOUT_DEF = {PHASES{8'h8C}}; // Default voltages
  int bias_cnt_r; // Cycles spent settling bias
  int low_cnt_r; // Cycles watchdog pin held low
  int w_quiet_r; // Cycles since last bus write
  logic steady; // Enable high, I/O supply up, no undervoltage or overtemperature
  assign steady = i_chip_en && i_io_good && !i_sys_uv && !i_ot_trip;
  // =====================================================
  // Helper counters
  always_ff @(posedge i_clk) begin
    bias_cnt_r <= (i_sys_rst || !(o_bias_en && !o_reg_allow && !o_soft_stop)) ? 0 : bias_cnt_r + 1;
  end
  always_ff @(posedge i_clk) begin
    low_cnt_r <= (i_sys_rst || i_host_watchdog_reset_n) ? 0 : low_cnt_r + 1;
  end
  always_ff @(posedge i_clk) begin
    w_quiet_r <= (i_sys_rst || (i_wvalid && o_wready)) ? 0 : ((w_quiet_r < 8) ? w_quiet_r + 1 : w_quiet_r);
  end
  // =====================================================
  // Assertions
  a_uv_dormant: assert property (i_sys_uv [*6] |-> !o_reg_allow)
    else $error("standby held during undervoltage");
  a_io_loss_off: assert property ((!i_io_good) [*6] |-> !o_reg_allow && !o_bias_en)
    else $error("running without io supply");
  a_ot_soft_stop: assert property (($rose(i_ot_trip) && o_reg_allow) ##1 i_ot_trip [*5]
    |-> o_soft_stop && o_reg_en == '0)
    else $error("no soft stop on overtemperature");
  a_ot_vout_dflt: assert property ($rose(o_soft_stop) |=> o_phase_output_voltage_setting == VOUT_DEF)
    else $error("voltages kept through thermal stop");
  a_ot_recover: assert property (($rose(i_ot_clear) && o_soft_stop && !i_ot_trip)
    ##1 (i_ot_clear && !i_ot_trip) [*4] |-> !o_soft_stop)
    else $error("thermal stop not left");
  a_bias_min: assert property ($rose(o_reg_allow) && !$past(o_soft_stop) && !$past(o_soft_stop, 2)
    |-> bias_cnt_r >= BIAS_CYCLES - 1)
    else $error("regulators allowed before bias settled");
  a_bias_max: assert property (bias_cnt_r <= BIAS_CYCLES + 4)
    else $error("bias settling too long");
  a_ce_low_off: assert property ((!i_chip_en) [*6] |-> !o_reg_allow && o_reg_en == '0)
    else $error("running with chip enable low");
  a_en_in_standby: assert property (o_reg_en != '0 |-> o_reg_allow || $past(o_reg_allow))
    else $error("regulator enabled outside standby");
  a_sync_lag: assert property ($rose(i_chip_en) && !o_bias_en |=> !o_bias_en)
    else $error("chip enable used unsynchronised");
  a_wdt_debounce: assert property (steady && $past(steady) && w_quiet_r >= 6 && o_reg_allow && $past(o_reg_allow)
    && o_phase_output_voltage_setting == VOUT_DEF && $past(o_phase_output_voltage_setting) != VOUT_DEF
    |-> low_cnt_r >= DEB_UNIT_CYCLES)
    else $error("voltages reverted before debounce");
  // Main scenarios reached
  c_thermal: cover property ($rose(o_soft_stop));
  c_irq: cover property ($rose(o_irq));
  c_standby: cover property ($rose(o_reg_allow));
endmodule
bind sfrm_top sfrm_top_chk #(.PHASES(PHASES), .BIAS_CYCLES(BIAS_CYCLES), .DEB_UNIT_CYCLES(DEB_UNIT_CYCLES)) u_chk (
  .i_clk, .i_sys_rst, .i_sys_uv, .i_io_good, .i_ot_trip, .i_ot_clear, .i_chip_en, .i_host_watchdog_reset_n,
  .i_wvalid, .o_wready, .o_reg_allow, .o_bias_en, .o_reg_en, .o_soft_stop, .o_irq, .o_phase_output_voltage_setting
);

// ===== system_fault_reset_manager_bench.sv
`timescale 1ns/1ps
`include "sfrm_cfg.svh"
// =====================================================
// Self-checking bench for the supervisor
module system_fault_reset_manager_bench;
  localparam int BIAS_T = 20; // Short bias settling
  localparam int DEB_T = 10; // Short debounce unit
  localparam int PULSE_T = 60; // Watchdog pulse length
  logic i_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic i_por_ok = 1'h1, i_sys_uv = 1'h0, i_io_good = 1'h1, i_ot_trip = 1'h0, i_ot_clear = 1'h0;
  logic i_warn_120 = 1'h0, i_warn_140 = 1'h0, ce_cmd = 1'h0, wdt_go = 1'h0, i_chip_en, i_host_watchdog_reset_n;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, o_supply_low_fall_level;
  logic [31:0] i_wdata = 32'h0, o_rdata, rd_d, o_phase_output_voltage_setting;
  logic [3:0] i_wstrb = 4'h0, o_reg_en;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_bias_en, o_reg_allow, o_soft_stop, o_irq;
  logic [1:0] o_bresp, o_rresp, rd_r;
  int num_errors = 0, cmp_count = 0, cycles = 0, n;
  // 250 MHz clock
  always #2 i_clk = ~i_clk;
  sfrm_top #(.PHASES(4), .BIAS_CYCLES(BIAS_T), .DEB_UNIT_CYCLES(DEB_T)) uut (.i_clk, .i_sys_rst, .i_por_ok,
    .i_sys_uv, .i_io_good, .i_ot_trip, .i_ot_clear, .i_warn_120, .i_warn_140, .i_chip_en, .i_host_watchdog_reset_n,
    .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_bias_en, .o_reg_allow,
    .o_reg_en, .o_soft_stop, .o_irq, .o_phase_output_voltage_setting, .o_supply_low_fall_level);
  sfrm_host #(.PULSE_CYCLES(PULSE_T)) u_host (.i_clk(i_clk), .i_ce_cmd(ce_cmd), .i_wdt_go(wdt_go),
    .o_chip_en(i_chip_en), .o_host_watchdog_reset_n(i_host_watchdog_reset_n));
  // =====================================================
  // Verdict and hang guard
  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  // =====================================================
  // Compare, bus and wait helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= 4'hF;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
    end while (!o_bvalid);
    chk(o_bresp, 32'h0);
    i_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'h0;
    end while (!o_rvalid);
    rd_d = o_rdata;
    rd_r = o_rresp;
    i_rready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_d, exp);
  endtask
  task automatic wait_allow(input logic v);
    n = 0;
    while (o_reg_allow !== v && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    chk(o_reg_allow, v);
  endtask
  task automatic pulse();
    @(posedge i_clk);
    wdt_go <= 1'h1;
    @(posedge i_clk);
    wdt_go <= 1'h0;
    repeat (PULSE_T + 8) @(posedge i_clk);
  endtask
  // =====================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    repeat (3) @(posedge i_clk);
    rc(`SFRM_OFF_CTRL, 32'h0);
    rc(`SFRM_OFF_WDT_CFG, 32'h3);
    rc(`SFRM_OFF_UVLO_CFG, 32'hF);
    for (int i = 0; i < 4; i++) rc(`SFRM_OFF_VOUT0 + 8'(4 * i), 32'h8C);
    rd(8'h40);
    chk(rd_r, 32'h2);
    chk(o_reg_allow, 32'h0);
    ce_cmd <= 1'h1;
    wait_allow(1'h1);
    chk(n >= BIAS_T, 32'h1);
    rc(`SFRM_OFF_STATUS, 32'h508);
    wr(`SFRM_OFF_CTRL, 32'h5);
    wr(`SFRM_OFF_VOUT0, 32'h40);
    wr(`SFRM_OFF_UVLO_CFG, 32'h20);
    repeat (2) @(posedge i_clk);
    chk(o_reg_en, 32'h5);
    chk(o_phase_output_voltage_setting[7:0], 32'h40);
    chk(o_supply_low_fall_level, 32'h20);
    // Soft reset clears off-class and self-clears
    wr(`SFRM_OFF_RESET, 32'h1);
    rc(`SFRM_OFF_RESET, 32'h0);
    rc(`SFRM_OFF_CTRL, 32'h0);
    rc(`SFRM_OFF_VOUT0, 32'h8C);
    // Watchdog: long debounce outlasts the pulse, short one reverts
    wr(`SFRM_OFF_CTRL, 32'h1);
    wr(`SFRM_OFF_VOUT0, 32'h40);
    pulse();
    rc(`SFRM_OFF_VOUT0, 32'h40);
    wr(`SFRM_OFF_WDT_CFG, 32'h0);
    pulse();
    rc(`SFRM_OFF_VOUT0, 32'h8C);
    rc(`SFRM_OFF_CTRL, 32'h1);
    rc(`SFRM_OFF_IRQ_STAT, 32'h4);
    wr(`SFRM_OFF_IRQ_CLR, 32'h4);
    // Warning interrupts: enabled, masked, then unmasked
    wr(`SFRM_OFF_IRQ_EN, 32'h3);
    i_warn_120 <= 1'h1;
    repeat (8) @(posedge i_clk);
    chk(o_irq, 32'h1);
    rc(`SFRM_OFF_IRQ_STAT, 32'h1);
    i_warn_120 <= 1'h0;
    wr(`SFRM_OFF_IRQ_CLR, 32'h1);
    wr(`SFRM_OFF_IRQ_EN, 32'h0);
    chk(o_irq, 32'h0);
    i_warn_140 <= 1'h1;
    repeat (8) @(posedge i_clk);
    chk(o_irq, 32'h0);
    rc(`SFRM_OFF_IRQ_STAT, 32'h2);
    wr(`SFRM_OFF_IRQ_EN, 32'h2);
    repeat (4) @(posedge i_clk);
    chk(o_irq, 32'h1);
    i_warn_140 <= 1'h0;
    wr(`SFRM_OFF_IRQ_CLR, 32'h2);
    repeat (4) @(posedge i_clk);
    chk(o_irq, 32'h0);
    // Thermal stop, bus still alive, then recovery
    wr(`SFRM_OFF_CTRL, 32'h3);
    wr(`SFRM_OFF_VOUT0, 32'h40);
    i_ot_trip <= 1'h1;
    repeat (8) @(posedge i_clk);
    chk(o_soft_stop, 32'h1);
    chk(o_reg_en, 32'h0);
    rd(`SFRM_OFF_STATUS);
    chk(rd_d & 32'h1F, 32'h10);
    rc(`SFRM_OFF_CTRL, 32'h0);
    rc(`SFRM_OFF_VOUT0, 32'h8C);
    i_ot_trip <= 1'h0;
    i_ot_clear <= 1'h1;
    wait_allow(1'h1);
    i_ot_clear <= 1'h0;
    // Chip enable low
    wr(`SFRM_OFF_CTRL, 32'h3);
    ce_cmd <= 1'h0;
    wait_allow(1'h0);
    repeat (2) @(posedge i_clk);
    chk(o_reg_en, 32'h0);
    rc(`SFRM_OFF_CTRL, 32'h0);
    ce_cmd <= 1'h1;
    wait_allow(1'h1);
    // Undervoltage keeps the part dormant
    i_sys_uv <= 1'h1;
    wait_allow(1'h0);
    repeat (30) @(posedge i_clk);
    chk(o_reg_allow, 32'h0);
    i_sys_uv <= 1'h0;
    wait_allow(1'h1);
    rc(`SFRM_OFF_UVLO_CFG, 32'h20);
    // I/O supply loss
    i_io_good <= 1'h0;
    wait_allow(1'h0);
    repeat (2) @(posedge i_clk);
    chk(o_bias_en, 32'h0);
    i_io_good <= 1'h1;
    wait_allow(1'h1);
    // Supply below power-on level
    i_por_ok <= 1'h0;
    repeat (8) @(posedge i_clk);
    chk(o_supply_low_fall_level, 32'hF);
    i_por_ok <= 1'h1;
    wait_allow(1'h1);
    end_of_test();
  end
endmodule
